// ==== hw/cpu_timer_pkg.sv ====
package cpu_timer_pkg;
  localparam int NUM_TIMERS = 3;
  localparam int CNT_W      = 32;
  localparam int PRE_W      = 16;
  localparam logic [CNT_W-1:0] PERIOD_RST = 32'hffff_ffff;
  localparam logic [PRE_W-1:0] PRE_RST    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 32'h0000_0000;
  localparam logic [PRE_W-1:0] PRE_ZERO   = 16'h0000;

  // Count clock sources of timer two
  typedef enum logic [1:0] {
    SRC_SYSCLK = 2'h0,
    SRC_OSC1   = 2'h1,
    SRC_OSC2   = 2'h2,
    SRC_EXT    = 2'h3
  } clk_src_e;

  // Software setup of one timer
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [PRE_W-1:0] prescale;
    logic             load;
    logic             run;
  } timer_cfg_s;
endpackage

// ==== hw/timer_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_channel
  import cpu_timer_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic             tick_in,
  input  wire timer_cfg_s       cfg,
  input  wire logic             irq_ack,
  output logic [CNT_W-1:0]      count,
  output logic                  irq
);
  logic [PRE_W-1:0] pre_reg;
  logic             pre_tick;
  logic             zero_hit;

  // Prescaler: value N gives one tick per N+1 input ticks, 0 passes all
  assign pre_tick = tick_in && (pre_reg == PRE_ZERO);
  assign zero_hit = cfg.run && pre_tick && (count == CNT_ZERO);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= PRE_RST;
    end else if (clk_en) begin
      if (cfg.load || pre_tick) begin
        pre_reg <= cfg.prescale;
      end else if (cfg.run && tick_in) begin
        pre_reg <= pre_reg - 16'h0001;
      end
    end
  end

  // Main down-counter, reloads itself from period on zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= PERIOD_RST;
    end else if (clk_en) begin
      if (cfg.load || zero_hit) begin
        count <= cfg.period;
      end else if (cfg.run && pre_tick) begin
        count <= count - 32'h0000_0001;
      end
    end
  end

  // Sticky flag; a new expiry wins over an acknowledge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      if (zero_hit) begin
        irq <= 1'b1;
      end else if (irq_ack) begin
        irq <= 1'b0;
      end
    end
  end

  a_expiry_sets_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && zero_hit |=> irq)
    else $error("expiry did not raise flag");
  a_flag_holds_pending: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq && !irq_ack |=> irq)
    else $error("flag dropped without ack");
  a_zero_reloads: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && zero_hit && !cfg.load |=> count == $past(cfg.period))
    else $error("counter did not reload period");
  a_count_steps: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && cfg.run && !cfg.load && pre_tick && count != CNT_ZERO
    |=> count == $past(count) - 32'h0000_0001)
    else $error("counter did not decrement on tick");
  a_count_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !cfg.load && !pre_tick |=> $stable(count))
    else $error("counter moved without prescaled tick");
endmodule
`default_nettype wire

// ==== hw/cpu_timers.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_timers
  import cpu_timer_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire timer_cfg_s       cfg0,
  input  wire timer_cfg_s       cfg1,
  input  wire timer_cfg_s       cfg2,
  input  wire clk_src_e         t2_src,
  input  wire logic             internal_oscillator_one,
  input  wire logic             internal_oscillator_two,
  input  wire logic             ext_clk,
  input  wire logic             t1_line_enable,
  input  wire logic [2:0]       irq_ack,
  output logic [CNT_W-1:0]      count0,
  output logic [CNT_W-1:0]      count1,
  output logic [CNT_W-1:0]      count2,
  output logic                  interrupt_expansion_block,
  output logic                  cpu_irq_line_thirteen,
  output logic                  cpu_irq_line_fourteen
);
  localparam int SYNC_N = 3;
  timer_cfg_s       cfg_arr [NUM_TIMERS];
  logic [CNT_W-1:0] cnt_arr [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tick_arr;
  logic [NUM_TIMERS-1:0] irq_arr;
  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;
  logic [SYNC_N-1:0] sync3_reg;
  logic [SYNC_N-1:0] last_reg;
  logic [SYNC_N-1:0] rise;

  assign cfg_arr[0] = cfg0;
  assign cfg_arr[1] = cfg1;
  assign cfg_arr[2] = cfg2;

  // Three-stage synchronisers on the foreign clocks; edge seen when 2 and 3 agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      last_reg  <= '0;
    end else if (clk_en) begin
      sync1_reg <= {ext_clk, internal_oscillator_two,
                    internal_oscillator_one};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < SYNC_N; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) last_reg[i] <= sync3_reg[i];
      end
    end
  end
  // Each source level must last two ref_clk cycles, a quarter of ref_clk at most, or edges are missed
  assign rise = sync3_reg & (sync2_reg ~^ sync3_reg) & ~last_reg;

  // Timer two source select, system clock by default
  always_comb begin
    unique case (t2_src)
      SRC_SYSCLK: tick_arr[2] = 1'b1;
      SRC_OSC1:   tick_arr[2] = rise[0];
      SRC_OSC2:   tick_arr[2] = rise[1];
      SRC_EXT:    tick_arr[2] = rise[2];
    endcase
  end
  assign tick_arr[0] = 1'b1;
  assign tick_arr[1] = 1'b1;

  // Three identical channels
  generate
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      timer_channel u_ch (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .tick_in (tick_arr[g]),
        .cfg     (cfg_arr[g]),
        .irq_ack (irq_ack[g]),
        .count   (cnt_arr[g]),
        .irq     (irq_arr[g])
      );
    end
  endgenerate

  assign count0 = cnt_arr[0];
  assign count1 = cnt_arr[1];
  assign count2 = cnt_arr[2];
  // Interrupt routing
  assign interrupt_expansion_block = irq_arr[0];
  assign cpu_irq_line_thirteen = irq_arr[1] & t1_line_enable;
  assign cpu_irq_line_fourteen = irq_arr[2];

  a_route_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    interrupt_expansion_block == irq_arr[0])
    else $error("timer zero routing wrong");
  a_route_thirteen: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cpu_irq_line_thirteen |-> irq_arr[1] && t1_line_enable)
    else $error("line thirteen wrong");
  a_route_fourteen: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cpu_irq_line_fourteen == irq_arr[2])
    else $error("line fourteen wrong");
  a_default_src: assert property (@(posedge ref_clk) disable iff (!arst_n)
    t2_src == SRC_SYSCLK |-> tick_arr[2])
    else $error("default source not ticking");
endmodule
`default_nettype wire

// ==== tb/irq_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_sink (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       en,
  input  wire logic [2:0] lines,
  output logic [2:0]      ack
);
  // Pulsed ack per pending line; held off so pending can be seen
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      ack <= 3'h0;
    else
      ack <= en ? (lines & ~ack) : 3'h0;
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpu_timer_pkg::*;
  logic             ref_clk = 1'b0;
  logic             arst_n = 1'b0;
  logic             slow = 1'b0;
  logic             line_en = 1'b0;
  logic             ack_en = 1'b0;
  logic             run_en = 1'b1;
  timer_cfg_s       cfg0 = '0;
  timer_cfg_s       cfg1 = '0;
  timer_cfg_s       cfg2 = '0;
  clk_src_e         src = SRC_SYSCLK;
  logic [2:0]       ack;
  logic [CNT_W-1:0] c0, c1, c2;
  logic             i0, i1, i2;
  int               err_count = 0;
  int               n_tests = 0;
  int               cycles = 0;
  always #5 ref_clk = ~ref_clk;
  cpu_timers cpu_timers_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(run_en), .cfg0(cfg0), .cfg1(cfg1), .cfg2(cfg2), .t2_src(src),
    .internal_oscillator_one(slow), .internal_oscillator_two(slow),
    .ext_clk(slow), .t1_line_enable(line_en), .irq_ack(ack),
    .count0(c0), .count1(c1), .count2(c2), .interrupt_expansion_block(i0),
    .cpu_irq_line_thirteen(i1), .cpu_irq_line_fourteen(i2));
  irq_sink irq_sink_inst (.ref_clk(ref_clk), .arst_n(arst_n), .en(ack_en),
    .lines({i2, i1, i0}), .ack(ack));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // Waits n rising edges, then samples at the settled falling edge
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Load on one edge, run from the next; sampled just after the load
  // Timer picked by index; module variables are written directly
  task automatic start(int t, logic [31:0] p, logic [15:0] ps);
    timer_cfg_s c;
    c = '{period: p, prescale: ps, load: 1'b1, run: 1'b0};
    @(posedge ref_clk);
    if (t == 0) cfg0 <= c;
    else if (t == 1) cfg1 <= c;
    else cfg2 <= c;
    c.load = 1'b0;
    c.run = 1'b1;
    @(posedge ref_clk);
    if (t == 0) cfg0 <= c;
    else if (t == 1) cfg1 <= c;
    else cfg2 <= c;
    @(negedge ref_clk);
  endtask
  task automatic test_t0();
    start(0, 32'h2, 16'h0);
    chk("count0 load", 32'h2, c0);
    cyc(2);
    chk("count0 zero", 32'h0, c0);
    cyc(1);
    chk("count0 reload", 32'h2, c0);
    chk("expansion irq", 32'h1, {31'h0, i0});
    cyc(4);
    chk("expansion pending", 32'h1, {31'h0, i0});
    @(posedge ref_clk);
    cfg0.run <= 1'b0;
    ack_en <= 1'b1;
    cyc(3);
    chk("expansion cleared", 32'h0, {31'h0, i0});
    ack_en <= 1'b0;
    $display("test_t0 done");
  endtask
  task automatic test_t1();
    start(1, 32'h1, 16'h2);
    cyc(2);
    chk("count1 held", 32'h1, c1);
    cyc(1);
    chk("count1 tick", 32'h0, c1);
    cyc(3);
    chk("count1 reload", 32'h1, c1);
    chk("line13 off", 32'h0, {31'h0, i1});
    @(posedge ref_clk);
    line_en <= 1'b1;
    cfg1.run <= 1'b0;
    @(negedge ref_clk);
    chk("line13 on", 32'h1, {31'h0, i1});
    $display("test_t1 done");
  endtask
  // Each slow source: four edges through period 3 gives one expiry
  task automatic test_t2();
    for (int s = 1; s < 4; s++) begin
      @(posedge ref_clk);
      src <= clk_src_e'(s);
      start(2, 32'h3, 16'h0);
      repeat (4) begin
        @(posedge ref_clk);
        slow <= 1'b1;
        repeat (4) @(posedge ref_clk);
        slow <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      cyc(6);
      chk("count2 source", 32'h3, c2);
      chk("line14", 32'h1, {31'h0, i2});
      @(posedge ref_clk);
      cfg2.run <= 1'b0;
      ack_en <= 1'b1;
      cyc(3);
      ack_en <= 1'b0;
    end
    $display("test_t2 done");
  endtask
  // Default source counts every cycle; clock enable low freezes it
  task automatic test_t2_sys();
    @(posedge ref_clk);
    src <= SRC_SYSCLK;
    start(2, 32'h5, 16'h0);
    cyc(2);
    chk("count2 sysclk", 32'h3, c2);
    @(posedge ref_clk);
    run_en <= 1'b0;
    cyc(3);
    chk("count2 frozen", 32'h2, c2);
    @(posedge ref_clk);
    run_en <= 1'b1;
    cfg2.run <= 1'b0;
    @(negedge ref_clk);
    $display("test_t2_sys done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Run is under two hundred cycles; ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    chk("count0 reset", PERIOD_RST, c0);
    test_t0();
    test_t1();
    test_t2();
    test_t2_sys();
    print_verdict();
  end
endmodule
`default_nettype wire
